/* rtl/power_path_mode_control.sv */
// Mode and supervision logic for a dual-input charger power path
//
// Functional notes
// - Boost-only mode regulates bypass node to the programmed bypass target.
// - Any on-the-go mode regulates bypass node to fixed 5.1V target.
// - Off or buck with valid high input: sense switch fully on.
// - Off with no valid high input: bypass tied to system via resistor.
// - Buck, charger disabled: system at battery regulation, battery switch open.
// - Buck-charge not charging: system at battery regulation, switch open.
// - Buck-charge charging: switch linear below minimum system, else closed.
// - Overloaded input lets battery supplement system just below battery.
// - Supplement closes switch per gauge sample; reopens below current threshold.
// - Every boost or on-the-go mode keeps battery switch closed.
// - High input valid only above UVLO, below OVLO, above system.
// - Validity change raises masked interrupt; validity and detail readable.
// - High input limit is 7 bits, low input limit 6 bits.
// - Reset defaults start buck, cap system, limit current 500mA.
// - Global shutdown returns every control bit to its default.
// - Input current reduced to hold each input at chosen target.
// - Current at cutoff and voltage still low turns sense switch off.
// - Input regulation activation raises bypass irq, clears good, sets detail.
// - Battery removed and system undervolted: discharge battery and system.
// - System first for energy; surplus to charger or bypass.
`timescale 1ns/1ps
module power_path_mode_control
  import power_path_pkg::*;
#(
  parameter int FILT_CYCLES = QUAL_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  global_shutdown_in,
  // Host settings
  input  wire logic                  cfg_write_in,
  input  wire logic [3:0]            mode_in,
  input  wire logic [BYP_SET_W-1:0]  bypass_voltage_target_in,
  input  wire logic [HV_ILIM_W-1:0]  hv_input_current_limit_in,
  input  wire logic [LV_ILIM_W-1:0]  lv_input_current_limit_in,
  input  wire logic [VREG_SEL_W-1:0] hv_input_voltage_target_in,
  input  wire logic [VREG_SEL_W-1:0] lv_input_voltage_target_in,
  input  wire logic                  hv_input_irq_mask_in,
  input  wire logic                  irq_read_in,
  // Comparator and analog status (asynchronous)
  input  wire logic                  hv_above_uvlo_in,
  input  wire logic                  hv_below_ovlo_in,
  input  wire logic                  hv_above_sys_in,
  input  wire logic                  lv_above_uvlo_in,
  input  wire logic                  lv_below_ovlo_in,
  input  wire logic                  lv_above_sys_in,
  input  wire logic                  charging_in,
  input  wire logic                  battery_node_below_minsys_in,
  input  wire logic                  input_overload_in,
  input  wire logic                  gauge_sample_in,
  input  wire logic                  gauge_continuous_in,
  input  wire logic                  battery_node_current_low_in,
  input  wire logic                  input_below_vreg_in,
  input  wire logic                  input_at_cutoff_in,
  input  wire logic                  battery_present_in,
  input  wire logic                  sys_below_uvlo_in,
  // Power-stage controls
  output logic [1:0]                 bypass_target_sel_out,
  output logic [BYP_SET_W-1:0]       bypass_voltage_target_out,
  output logic                       hv_input_sense_switch_out,
  output logic                       bypass_weak_tie_out,
  output logic                       sys_at_battery_node_reg_out,
  output logic                       battery_isolation_switch_out,
  output logic                       battery_switch_linear_out,
  output logic                       supplement_active_out,
  output logic                       buck_enable_out,
  output logic                       boost_enable_out,
  output logic [HV_ILIM_W-1:0]       hv_input_current_limit_out,
  output logic [LV_ILIM_W-1:0]       lv_input_current_limit_out,
  output logic [VREG_SEL_W-1:0]      hv_input_voltage_target_out,
  output logic [VREG_SEL_W-1:0]      lv_input_voltage_target_out,
  output logic                       input_vreg_active_out,
  output logic                       discharge_out,
  // Status
  output logic                       hv_input_valid_flag_out,
  output logic [DTLS_W-1:0]          hv_input_detail_status_out,
  output logic                       lv_input_valid_flag_out,
  output logic                       hv_input_status_irq_out,
  output logic                       bypass_node_irq_out,
  output logic                       bypass_node_good_flag_out,
  output logic [DTLS_W-1:0]          bypass_node_detail_status_out
);

  if (FILT_CYCLES < 1 || FILT_CYCLES > 255) begin : g_filt_range
    $error("power_path_mode_control: FILT_CYCLES out of range");
  end

  // ********************************
  // Mode decode helpers
  // ********************************
  function automatic logic is_otg(input logic [3:0] m);
    return (m == MODE_OTG_A) || (m == MODE_OTG_E) || (m == MODE_OTG_F);
  endfunction

  function automatic logic is_boost(input logic [3:0] m);
    return (m == MODE_BOOST) || (m == MODE_BOOST_C) ||
           (m == MODE_BOOST_D) || is_otg(m);
  endfunction

  function automatic logic is_buck(input logic [3:0] m);
    return (m == MODE_BUCK) || (m == MODE_BUCK_CHG);
  endfunction

  // ********************************
  // Input qualification
  // ********************************
  status_if hv_stat ();
  status_if lv_stat ();

  input_qualifier #(.FILT_CYCLES(FILT_CYCLES)) u_hv_qual (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .above_uvlo_in (hv_above_uvlo_in),
    .below_ovlo_in (hv_below_ovlo_in),
    .above_sys_in  (hv_above_sys_in),
    .stat          (hv_stat.src)
  );

  input_qualifier #(.FILT_CYCLES(FILT_CYCLES)) u_lv_qual (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .above_uvlo_in (lv_above_uvlo_in),
    .below_ovlo_in (lv_below_ovlo_in),
    .above_sys_in  (lv_above_sys_in),
    .stat          (lv_stat.src)
  );

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [9:0]            s1;
    logic [9:0]            s2;
    logic [3:0]            mode;
    logic [BYP_SET_W-1:0]  byp_set;
    logic [HV_ILIM_W-1:0]  hv_ilim;
    logic [LV_ILIM_W-1:0]  lv_ilim;
    logic [VREG_SEL_W-1:0] hv_vreg;
    logic [VREG_SEL_W-1:0] lv_vreg;
    logic                  mask;
    logic                  hv_irq;
    logic                  byp_irq;
    logic                  vreg_act;
    logic                  sense_off;
    logic                  battery_isolation_switch_close;
    logic                  sample_hold;
  } st_s;

  st_s st_r;
  st_s st_nxt;

  // Synchronised analog flags
  logic chg_s, below_min_s, overload_s, sample_s, cont_s, ilow_s;
  logic below_vreg_s, cutoff_s, bat_pres_s, sys_uv_s;
  logic vreg_now, supplement;

  assign {chg_s, below_min_s, overload_s, sample_s, cont_s, ilow_s,
          below_vreg_s, cutoff_s, bat_pres_s, sys_uv_s} = st_r.s2;

  assign vreg_now   = below_vreg_s;
  assign supplement = overload_s && !is_boost(st_r.mode);

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = {charging_in, battery_node_below_minsys_in, input_overload_in,
                 gauge_sample_in, gauge_continuous_in, battery_node_current_low_in,
                 input_below_vreg_in, input_at_cutoff_in,
                 battery_present_in, sys_below_uvlo_in};
    st_nxt.s2 = st_r.s1;
    if (cfg_write_in) begin
      st_nxt.mode    = mode_in;
      st_nxt.byp_set = bypass_voltage_target_in;
      st_nxt.hv_ilim = hv_input_current_limit_in;
      st_nxt.lv_ilim = lv_input_current_limit_in;
      st_nxt.hv_vreg = hv_input_voltage_target_in;
      st_nxt.lv_vreg = lv_input_voltage_target_in;
      st_nxt.mask    = hv_input_irq_mask_in;
    end
    // Read clears; a simultaneous event still sets
    if (irq_read_in) begin
      st_nxt.hv_irq  = 1'b0;
      st_nxt.byp_irq = 1'b0;
    end
    if (hv_stat.changed) begin
      st_nxt.hv_irq = 1'b1;
    end
    st_nxt.vreg_act = vreg_now;
    if (vreg_now && !st_r.vreg_act) begin
      st_nxt.byp_irq = 1'b1;
    end
    // Cutoff latch releases once the input recovers or goes invalid
    if (cutoff_s && below_vreg_s) begin
      st_nxt.sense_off = 1'b1;
    end else if (!below_vreg_s || !hv_stat.valid) begin
      st_nxt.sense_off = 1'b0;
    end
    // Gauge sampling during supplement
    if (!supplement) begin
      st_nxt.sample_hold = 1'b0;
    end else if (sample_s) begin
      st_nxt.sample_hold = 1'b1;
    end else if (!cont_s || ilow_s) begin
      st_nxt.sample_hold = 1'b0;
    end
    if (cont_s && ilow_s) begin
      st_nxt.sample_hold = 1'b0;
    end
    st_nxt.battery_isolation_switch_close = 1'b0;
    if (is_boost(st_r.mode)) begin
      st_nxt.battery_isolation_switch_close = 1'b1;
    end else if (st_r.mode == MODE_BUCK_CHG && chg_s && !below_min_s) begin
      st_nxt.battery_isolation_switch_close = 1'b1;
    end else if (supplement) begin
      st_nxt.battery_isolation_switch_close = st_nxt.sample_hold;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || global_shutdown_in) begin
      st_r         <= '0;
      st_r.mode    <= MODE_RST;
      st_r.hv_ilim <= HV_ILIM_RST;
      st_r.lv_ilim <= LV_ILIM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************
  // Power-stage outputs
  // ********************************
  always_comb begin
    bypass_target_sel_out = TGT_OFF;
    if (st_r.mode == MODE_BOOST) begin
      bypass_target_sel_out = TGT_SETTING;
    end else if (is_otg(st_r.mode)) begin
      bypass_target_sel_out = TGT_OTG;
    end else if (hv_stat.valid) begin
      bypass_target_sel_out = TGT_INPUT;
    end
  end

  assign bypass_voltage_target_out = st_r.byp_set;
  assign hv_input_sense_switch_out = (st_r.mode == MODE_OFF ||
    is_buck(st_r.mode)) && hv_stat.valid && !st_r.sense_off;
  assign bypass_weak_tie_out = (st_r.mode == MODE_OFF) &&
                               !hv_stat.valid;
  assign sys_at_battery_node_reg_out = (st_r.mode == MODE_BUCK) ||
    (st_r.mode == MODE_BUCK_CHG && !chg_s);
  assign battery_isolation_switch_out = st_r.battery_isolation_switch_close;
  assign battery_switch_linear_out = (st_r.mode == MODE_BUCK_CHG) &&
    chg_s && below_min_s && !supplement;
  assign supplement_active_out = supplement;
  // System is served first; the converter direction decides where surplus goes
  assign buck_enable_out  = is_buck(st_r.mode);
  assign boost_enable_out = is_boost(st_r.mode);
  assign hv_input_current_limit_out  = st_r.hv_ilim;
  assign lv_input_current_limit_out  = st_r.lv_ilim;
  assign hv_input_voltage_target_out = st_r.hv_vreg;
  assign lv_input_voltage_target_out = st_r.lv_vreg;
  assign input_vreg_active_out = st_r.vreg_act;
  assign discharge_out = !bat_pres_s && sys_uv_s;

  // ********************************
  // Status outputs
  // ********************************
  assign hv_input_valid_flag_out    = hv_stat.valid;
  assign hv_input_detail_status_out = hv_stat.detail;
  assign lv_input_valid_flag_out    = lv_stat.valid;
  assign hv_input_status_irq_out    = st_r.hv_irq && !st_r.mask;
  assign bypass_node_irq_out        = st_r.byp_irq;
  assign bypass_node_good_flag_out  = !st_r.vreg_act;
  assign bypass_node_detail_status_out =
    {st_r.vreg_act, {(DTLS_W-1){1'b0}}};

  // ********************************
  // Checks
  // ********************************
  sequence s_change;
    hv_stat.changed && !irq_read_in;
  endsequence

  a_boost_battery_isolation_switch : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    is_boost(st_r.mode) && $stable(st_r.mode) |->
      battery_isolation_switch_out)
    else $error("battery switch open in boost mode");

  a_otg_target : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    is_otg(st_r.mode) |-> bypass_target_sel_out == TGT_OTG)
    else $error("otg mode without fixed target");

  a_boost_target : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    st_r.mode == MODE_BOOST |-> bypass_target_sel_out == TGT_SETTING)
    else $error("boost mode without programmed target");

  a_irq_latch : assert property (@(posedge clk_in)
    disable iff (!rst_n_in || global_shutdown_in)
    s_change ##1 !irq_read_in [*2] |-> st_r.hv_irq [*2])
    else $error("input irq flag lost before read");

  a_mask_gates : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    st_r.mask |-> !hv_input_status_irq_out)
    else $error("masked irq visible");

  a_vreg_irq : assert property (@(posedge clk_in)
    disable iff (!rst_n_in || global_shutdown_in)
    $rose(st_r.vreg_act) |-> st_r.byp_irq && !bypass_node_good_flag_out &&
      bypass_node_detail_status_out[DTLS_VREG_BIT])
    else $error("vreg activation not reported");

  a_shutdown_mode : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    global_shutdown_in |=> st_r.mode == MODE_RST &&
      st_r.hv_ilim == HV_ILIM_RST)
    else $error("shutdown did not restore defaults");

  a_weak_tie : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    bypass_weak_tie_out |-> !hv_input_sense_switch_out)
    else $error("weak tie with sense switch on");

  a_discharge : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    discharge_out |-> !bat_pres_s && sys_uv_s)
    else $error("discharge without cause");

  a_buck_open : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    st_r.mode == MODE_BUCK && $past(st_r.mode) == MODE_BUCK &&
      !$past(supplement) |-> !battery_isolation_switch_out)
    else $error("battery switch closed in plain buck");

  a_cutoff_off : assert property (@(posedge clk_in)
    disable iff (!rst_n_in || global_shutdown_in)
    cutoff_s && below_vreg_s |=> !hv_input_sense_switch_out)
    else $error("sense switch on at cutoff");

endmodule

/* pkg/power_path_pkg.sv */
// Package: mode codes, field widths, reset defaults and timing for the power path
package power_path_pkg;

  // ********************************
  // Mode encodings
  // ********************************
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_BUCK       = 4'h4;
  localparam logic [3:0] MODE_BUCK_CHG   = 4'h5;
  localparam logic [3:0] MODE_BOOST      = 4'h8;
  localparam logic [3:0] MODE_OTG_A      = 4'ha;
  localparam logic [3:0] MODE_BOOST_C    = 4'hc;
  localparam logic [3:0] MODE_BOOST_D    = 4'hd;
  localparam logic [3:0] MODE_OTG_E      = 4'he;
  localparam logic [3:0] MODE_OTG_F      = 4'hf;

  // ********************************
  // Field widths
  // ********************************
  localparam int BYP_SET_W  = 7;
  localparam int HV_ILIM_W  = 7;
  localparam int LV_ILIM_W  = 6;
  localparam int VREG_SEL_W = 2;
  localparam int DTLS_W     = 4;
  localparam int DTLS_VREG_BIT = 3;

  // ********************************
  // Reset defaults (buck, 500 mA)
  // ********************************
  localparam logic [3:0]           MODE_RST    = MODE_BUCK;
  localparam logic [HV_ILIM_W-1:0] HV_ILIM_RST = 7'h0f;
  localparam logic [LV_ILIM_W-1:0] LV_ILIM_RST = 6'h0f;

  // ********************************
  // Target selector codes and timing
  // ********************************
  localparam logic [1:0] TGT_OFF    = 2'h0;
  localparam logic [1:0] TGT_SETTING = 2'h1;
  localparam logic [1:0] TGT_OTG    = 2'h2;
  localparam logic [1:0] TGT_INPUT  = 2'h3;

  localparam int CLK_PERIOD_PS   = 5000;
  localparam int QUAL_TIME_NS    = 100;
  localparam int QUAL_CYCLES     =
    (QUAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

/* pkg/status_if.sv */
// Interface: status bits shared between the qualifier and the top
`timescale 1ns/1ps
interface status_if;
  logic valid;
  logic changed;
  logic [power_path_pkg::DTLS_W-1:0] detail;
  modport src  (output valid, output changed, output detail);
  modport sink (input  valid, input  changed, input  detail);
endinterface

/* rtl/input_qualifier.sv */
// Input qualifier: synchronises comparator results and judges input validity
`timescale 1ns/1ps
module input_qualifier
  import power_path_pkg::*;
#(
  parameter int FILT_CYCLES = QUAL_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic above_uvlo_in,
  input  wire logic below_ovlo_in,
  input  wire logic above_sys_in,
  status_if.src     stat
);

  if (FILT_CYCLES < 1 || FILT_CYCLES > 255) begin : g_filt_range
    $error("input_qualifier: FILT_CYCLES out of range");
  end

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [7:0] cnt;
    logic       valid;
    logic       changed;
  } q_s;

  q_s q_r;
  q_s q_nxt;
  logic raw_ok;

  // ********************************
  // Validity with a short stability filter
  // ********************************
  assign raw_ok = &q_r.s2;

  always_comb begin
    q_nxt         = q_r;
    q_nxt.s1      = {above_uvlo_in, below_ovlo_in, above_sys_in};
    q_nxt.s2      = q_r.s1;
    q_nxt.changed = 1'b0;
    if (raw_ok == q_r.valid) begin
      q_nxt.cnt = 8'h00;
    end else if (q_r.cnt >= 8'(FILT_CYCLES - 1)) begin
      q_nxt.cnt     = 8'h00;
      q_nxt.valid   = raw_ok;
      q_nxt.changed = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign stat.valid   = q_r.valid;
  assign stat.changed = q_r.changed;
  assign stat.detail  = {1'b0, q_r.s2};

  a_valid_needs_all : assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    $rose(q_r.valid) |-> $past(raw_ok))
    else $error("input marked valid without all three conditions");

endmodule

/* testbench/source_model.sv */
// Far-side model: charge sources as seen through the input comparators
`timescale 1ns/1ps
module source_model (
  input  wire logic [1:0] hv_level_in,
  input  wire logic       lv_on_in,
  output logic            hv_above_uvlo_out,
  output logic            hv_below_ovlo_out,
  output logic            hv_above_sys_out,
  output logic            lv_above_uvlo_out,
  output logic            lv_below_ovlo_out,
  output logic            lv_above_sys_out
);
  // ****************************************
  // Comparator levels
  // ****************************************
  // Level 0 absent, 1 in range, 2 overvoltage, 3 above lockout but under
  // the system rail; a real source sags below the rail before it vanishes
  assign hv_above_uvlo_out = hv_level_in != 2'h0;
  assign hv_below_ovlo_out = hv_level_in != 2'h2;
  assign hv_above_sys_out  = hv_level_in == 2'h1 || hv_level_in == 2'h2;
  assign lv_above_uvlo_out = lv_on_in;
  assign lv_below_ovlo_out = 1'b1;
  assign lv_above_sys_out  = lv_on_in;
endmodule

/* testbench/power_path_mode_control_bench.sv */
// Self-checking bench for the power path mode and supervision block
`timescale 1ns/1ps
module power_path_mode_control_bench;
  import power_path_pkg::*;
  localparam int FILT = 4;
  logic       clk_in, rst_n_in, global_shutdown_in, cfg_write_in;
  logic [3:0] mode_in;
  logic [6:0] bypass_voltage_target_in, hv_input_current_limit_in;
  logic [5:0] lv_input_current_limit_in;
  logic [1:0] hv_input_voltage_target_in, lv_input_voltage_target_in;
  logic       hv_input_irq_mask_in, irq_read_in, lv_on;
  logic       hv_above_uvlo_in, hv_below_ovlo_in, hv_above_sys_in;
  logic       lv_above_uvlo_in, lv_below_ovlo_in, lv_above_sys_in;
  logic       charging_in, battery_node_below_minsys_in, input_overload_in;
  logic       gauge_sample_in, gauge_continuous_in, battery_node_current_low_in;
  logic       input_below_vreg_in, input_at_cutoff_in;
  logic       battery_present_in, sys_below_uvlo_in;
  logic [1:0] hv_level, bypass_target_sel_out;
  logic [1:0] hv_input_voltage_target_out, lv_input_voltage_target_out;
  logic [6:0] bypass_voltage_target_out, hv_input_current_limit_out;
  logic [5:0] lv_input_current_limit_out;
  logic [3:0] hv_input_detail_status_out, bypass_node_detail_status_out;
  logic hv_input_sense_switch_out, bypass_weak_tie_out, sys_at_battery_node_reg_out;
  logic battery_isolation_switch_out, battery_switch_linear_out;
  logic supplement_active_out, buck_enable_out, boost_enable_out;
  logic input_vreg_active_out, discharge_out, hv_input_valid_flag_out;
  logic lv_input_valid_flag_out, hv_input_status_irq_out;
  logic bypass_node_irq_out, bypass_node_good_flag_out;
  int   n_fail, total_checks;

  source_model u_src (.hv_level_in(hv_level), .lv_on_in(lv_on),
    .hv_above_uvlo_out(hv_above_uvlo_in), .hv_below_ovlo_out(hv_below_ovlo_in),
    .hv_above_sys_out(hv_above_sys_in), .lv_above_uvlo_out(lv_above_uvlo_in),
    .lv_below_ovlo_out(lv_below_ovlo_in), .lv_above_sys_out(lv_above_sys_in));

  power_path_mode_control #(.FILT_CYCLES(FILT)) u_dut (.clk_in, .rst_n_in,
    .global_shutdown_in, .cfg_write_in, .mode_in, .bypass_voltage_target_in,
    .hv_input_current_limit_in, .lv_input_current_limit_in,
    .hv_input_voltage_target_in, .lv_input_voltage_target_in,
    .hv_input_irq_mask_in, .irq_read_in, .hv_above_uvlo_in, .hv_below_ovlo_in,
    .hv_above_sys_in, .lv_above_uvlo_in, .lv_below_ovlo_in, .lv_above_sys_in,
    .charging_in, .battery_node_below_minsys_in, .input_overload_in, .gauge_sample_in,
    .gauge_continuous_in, .battery_node_current_low_in, .input_below_vreg_in,
    .input_at_cutoff_in, .battery_present_in, .sys_below_uvlo_in,
    .bypass_target_sel_out, .bypass_voltage_target_out,
    .hv_input_sense_switch_out, .bypass_weak_tie_out, .sys_at_battery_node_reg_out,
    .battery_isolation_switch_out, .battery_switch_linear_out,
    .supplement_active_out, .buck_enable_out, .boost_enable_out,
    .hv_input_current_limit_out, .lv_input_current_limit_out,
    .hv_input_voltage_target_out, .lv_input_voltage_target_out,
    .input_vreg_active_out, .discharge_out, .hv_input_valid_flag_out,
    .hv_input_detail_status_out, .lv_input_valid_flag_out,
    .hv_input_status_irq_out, .bypass_node_irq_out, .bypass_node_good_flag_out,
    .bypass_node_detail_status_out);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Sampling on the falling edge keeps checks clear of the launch edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic cfg(input logic [3:0] m, input logic mk = 1'b0);
    @(posedge clk_in);
    mode_in      <= m;
    hv_input_irq_mask_in <= mk;
    cfg_write_in <= 1'b1;
    @(posedge clk_in);
    cfg_write_in <= 1'b0;
    wt(3);
  endtask

  task automatic pulse_read();
    @(posedge clk_in);
    irq_read_in <= 1'b1;
    @(posedge clk_in);
    irq_read_in <= 1'b0;
    wt(2);
  endtask

  // Synchroniser, filter and flag update need FILT plus a few cycles
  task automatic hv_set(input logic [1:0] lvl, input logic exp);
    @(posedge clk_in);
    hv_level <= lvl;
    wt(FILT + 6);
    chk(hv_input_valid_flag_out, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(buck_enable_out, 1'b1);
    chk(hv_input_current_limit_out, HV_ILIM_RST);
    chk(lv_input_current_limit_out, LV_ILIM_RST);
    chk(sys_at_battery_node_reg_out, 1'b1);
    chk(battery_isolation_switch_out, 1'b0);
    @(posedge clk_in);
    charging_in <= 1'b1;
    wt(4);
    chk(battery_isolation_switch_out, 1'b0);
    chk(bypass_node_good_flag_out, 1'b1);
  endtask

  task automatic t_boost();
    logic [3:0] m[5];
    m = '{MODE_OTG_A, MODE_OTG_E, MODE_OTG_F, MODE_BOOST_C, MODE_BOOST_D};
    @(posedge clk_in);
    bypass_voltage_target_in   <= 7'h55;
    hv_input_current_limit_in  <= 7'h7f;
    lv_input_current_limit_in  <= 6'h3f;
    hv_input_voltage_target_in <= 2'h3;
    lv_input_voltage_target_in <= 2'h2;
    cfg(MODE_BOOST);
    chk(bypass_target_sel_out, TGT_SETTING);
    chk(bypass_voltage_target_out, 8'h55);
    chk(hv_input_current_limit_out, 8'h7f);
    chk(lv_input_current_limit_out, 8'h3f);
    chk(hv_input_voltage_target_out, 8'h03);
    chk(lv_input_voltage_target_out, 8'h02);
    chk(battery_isolation_switch_out, 1'b1);
    chk(boost_enable_out, 1'b1);
    for (int i = 0; i < 5; i++) begin
      cfg(m[i]);
      chk(battery_isolation_switch_out, 1'b1);
      if (i < 3) chk(bypass_target_sel_out, TGT_OTG);
    end
    @(posedge clk_in);
    global_shutdown_in <= 1'b1;
    @(posedge clk_in);
    global_shutdown_in <= 1'b0;
    wt(2);
    chk(buck_enable_out, 1'b1);
    chk(boost_enable_out, 1'b0);
    chk(hv_input_current_limit_out, HV_ILIM_RST);
  endtask

  task automatic t_input();
    cfg(MODE_OFF);
    chk(bypass_weak_tie_out, 1'b1);
    hv_set(2'h3, 1'b0);
    hv_set(2'h1, 1'b1);
    chk(hv_input_detail_status_out, 8'h07);
    chk(bypass_target_sel_out, TGT_INPUT);
    chk(hv_input_sense_switch_out, 1'b1);
    chk(bypass_weak_tie_out, 1'b0);
    wt(5);
    chk(hv_input_status_irq_out, 1'b1);
    pulse_read();
    chk(hv_input_status_irq_out, 1'b0);
    cfg(MODE_OFF, 1'b1);
    hv_set(2'h2, 1'b0);
    chk(hv_input_status_irq_out, 1'b0);
    cfg(MODE_OFF);
    chk(hv_input_status_irq_out, 1'b1);
    pulse_read();
    @(posedge clk_in);
    lv_on <= 1'b1;
    hv_set(2'h1, 1'b1);
    chk(lv_input_valid_flag_out, 1'b1);
    cfg(MODE_BUCK_CHG);
    chk(hv_input_sense_switch_out, 1'b1);
  endtask

  task automatic t_vreg();
    pulse_read();
    @(posedge clk_in);
    input_below_vreg_in <= 1'b1;
    wt(4);
    chk(input_vreg_active_out, 1'b1);
    chk(bypass_node_irq_out, 1'b1);
    chk(bypass_node_good_flag_out, 1'b0);
    chk(bypass_node_detail_status_out[3], 1'b1);
    chk(hv_input_sense_switch_out, 1'b1);
    @(posedge clk_in);
    input_at_cutoff_in <= 1'b1;
    wt(4);
    chk(hv_input_sense_switch_out, 1'b0);
    @(posedge clk_in);
    input_below_vreg_in <= 1'b0;
    input_at_cutoff_in  <= 1'b0;
    wt(4);
    chk(hv_input_sense_switch_out, 1'b1);
  endtask

  task automatic t_charge();
    @(posedge clk_in);
    charging_in <= 1'b0;
    wt(4);
    chk(sys_at_battery_node_reg_out, 1'b1);
    chk(battery_isolation_switch_out, 1'b0);
    @(posedge clk_in);
    charging_in          <= 1'b1;
    battery_node_below_minsys_in <= 1'b1;
    wt(4);
    chk(battery_switch_linear_out, 1'b1);
    @(posedge clk_in);
    battery_node_below_minsys_in <= 1'b0;
    wt(4);
    chk(battery_switch_linear_out, 1'b0);
    chk(battery_isolation_switch_out, 1'b1);
    @(posedge clk_in);
    charging_in       <= 1'b0;
    input_overload_in <= 1'b1;
    gauge_sample_in   <= 1'b1;
    wt(4);
    chk(supplement_active_out, 1'b1);
    chk(battery_isolation_switch_out, 1'b1);
    @(posedge clk_in);
    gauge_continuous_in <= 1'b1;
    battery_node_current_low_in <= 1'b1;
    wt(4);
    chk(battery_isolation_switch_out, 1'b0);
    cfg(MODE_BOOST);
    chk(supplement_active_out, 1'b0);
    @(posedge clk_in);
    battery_present_in <= 1'b0;
    sys_below_uvlo_in  <= 1'b1;
    wt(4);
    chk(discharge_out, 1'b1);
    @(posedge clk_in);
    battery_present_in <= 1'b1;
    wt(4);
    chk(discharge_out, 1'b0);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, reset, watchdog and main sequence
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end

  initial begin
    {rst_n_in, global_shutdown_in, cfg_write_in, mode_in} = '0;
    {bypass_voltage_target_in, hv_input_current_limit_in} = '0;
    {lv_input_current_limit_in, hv_input_voltage_target_in} = '0;
    {lv_input_voltage_target_in, hv_input_irq_mask_in, irq_read_in} = '0;
    {hv_level, lv_on, charging_in, battery_node_below_minsys_in} = '0;
    {input_overload_in, gauge_sample_in, gauge_continuous_in} = '0;
    {battery_node_current_low_in, input_below_vreg_in, input_at_cutoff_in} = '0;
    {battery_present_in, sys_below_uvlo_in} = 2'h2;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wt(4);
    t_reset();
    t_boost();
    t_input();
    t_vreg();
    t_charge();
    wrap_up();
  end
endmodule
